// ---- hdl/dmrt_pkg.sv ----
package dmrt_pkg;

  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  localparam int BIT_HIGH_OVF = 7;
  localparam int BIT_LOW_OVF = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_EXT_CLK = 0;

  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_irq_en;
    logic lfo_capture_en;
    logic split_mode_sel;
    logic run_ctrl;
    logic unused_bit;
    logic ext_clk_sel;
  } dmrt_control_s;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmrt_write_s;

  localparam dmrt_control_s CONTROL_RESET = dmrt_control_s'(RESET_BYTE);

endpackage

// ---- hdl/dmrt_timer.sv ----
`timescale 1ns/1ps
// How it works
// [RULE_01] With split clear the two count bytes form one 16-bit auto-reloading up-counter.
// [RULE_02] In 16-bit mode a roll from 0xFFFF to 0x0000 loads both reload bytes and sets the high overflow flag.
// [RULE_03] In 16-bit mode every full overflow requests an interrupt when the outside enable is high.
// [RULE_04] In 16-bit mode a low-byte roll also interrupts when the low interrupt enable is set.
// [RULE_05] With split set two 8-bit counters each reload from their own reload byte.
// [RULE_06] Run gates counting; in split mode it gates only the high counter and the low one always runs.
// [RULE_07] Each byte counts on the system clock when its select is 1, else on clock/12 or external/8; in 16-bit mode the high byte steps on the low carry.
// [RULE_08] The external divide-by-8 timebase is synchronised to the system clock before use.
// [RULE_09] High flag sets on a high byte roll, low flag on every low byte roll in any mode.
// [RULE_10] In split mode a high overflow interrupts, and with low enable either overflow does.
// [RULE_11] Overflow flags are never cleared by hardware; only software clears them.
// [RULE_12] With capture and interrupts enabled a rising oscillator edge copies the count to reload and interrupts.
// [RULE_13] Control holds high flag 7, low flag 6, low enable 5, capture 4, split 3, run 2, ext clock 0, reset zero.
// [RULE_14] Control bit 1 reads zero and ignores writes.
// [RULE_15] Count bytes are readable and writable and hold the count halves or the two split counts.
// [RULE_16] The interrupt output is high flag, or low flag with low enable, or a capture, gated by the outside enable.
// [RULE_17] A software write to a count or reload byte beats a same-cycle increment or reload.
module dmrt_timer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic high_byte_clk_sel,
  input wire logic low_byte_clk_sel,
  input wire logic timer_irq_en,
  input wire logic ext_osc_clk,
  input wire logic lfo_out,
  output logic irq_req
);

  dmrt_pkg::dmrt_write_s wr;
  dmrt_pkg::dmrt_control_s timer_control;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [3:0] sys_div_cnt;
  logic sys_tick;
  logic [2:0] ext_sync;
  logic ext_level;
  logic [2:0] ext_div_cnt;
  logic ext_tick;
  logic [2:0] lfo_sync;
  logic lfo_level;
  logic lfo_rise;
  logic low_tick;
  logic high_tick;
  logic low_en;
  logic high_en;
  logic low_roll;
  logic high_roll;
  logic capture;
  logic next_irq;

  assign wr = '{wr_en: sfr_wr, addr: sfr_addr, wdata: sfr_wdata};

  function automatic logic wr_hit(input dmrt_pkg::dmrt_write_s w, input logic [7:0] a);
    wr_hit = w.wr_en && (w.addr == a);
  endfunction

  // System clock divided by 12
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sys_div_cnt <= '0;
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= (sys_div_cnt == dmrt_pkg::SYS_DIV_LAST);
      if (sys_div_cnt == dmrt_pkg::SYS_DIV_LAST) begin
        sys_div_cnt <= '0;
      end else begin
        sys_div_cnt <= sys_div_cnt + 4'h1;
      end
    end
  end

  // Stable once second and third stages agree
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ext_sync <= '0;
      ext_level <= 1'b0;
      lfo_sync <= '0;
      lfo_level <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_osc_clk}; // RULE_08
      lfo_sync <= {lfo_sync[1:0], lfo_out};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level <= ext_sync[2];
      end
      if (lfo_sync[1] == lfo_sync[2]) begin
        lfo_level <= lfo_sync[2];
      end
    end
  end

  // External oscillator divided by 8, counted on synchronised rising edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ext_div_cnt <= '0;
      ext_tick <= 1'b0;
    end else begin
      ext_tick <= 1'b0;
      if (ext_sync[1] == ext_sync[2] && ext_sync[2] && !ext_level) begin
        ext_tick <= (ext_div_cnt == dmrt_pkg::EXT_DIV_LAST); // RULE_08
        ext_div_cnt <= ext_div_cnt + 3'h1;
      end
    end
  end

  assign lfo_rise = (lfo_sync[1] == lfo_sync[2]) && lfo_sync[2] && !lfo_level;

  // Per-byte timebase selection
  always_comb begin
    low_tick = low_byte_clk_sel ? 1'b1 : (timer_control.ext_clk_sel ? ext_tick : sys_tick); // RULE_07
    high_tick = high_byte_clk_sel ? 1'b1 : (timer_control.ext_clk_sel ? ext_tick : sys_tick); // RULE_07
  end

  // Split: low always runs; joined: run gates both and high advances on carry
  always_comb begin
    if (timer_control.split_mode_sel) begin
      low_en = low_tick; // RULE_06
      high_en = high_tick && timer_control.run_ctrl; // RULE_06
    end else begin
      low_en = low_tick && timer_control.run_ctrl; // RULE_01
      high_en = low_en && (count_low_byte == dmrt_pkg::BYTE_MAX); // RULE_01
    end
    low_roll = low_en && (count_low_byte == dmrt_pkg::BYTE_MAX);
    high_roll = high_en && (count_high_byte == dmrt_pkg::BYTE_MAX);
    capture = timer_control.lfo_capture_en && timer_irq_en && lfo_rise; // RULE_12
  end

  // Low count byte; software write wins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count_low_byte <= dmrt_pkg::RESET_BYTE;
    end else if (wr_hit(wr, dmrt_pkg::ADDR_COUNT_LOW)) begin
      count_low_byte <= wr.wdata; // RULE_15 RULE_17
    end else if (low_roll && (timer_control.split_mode_sel || high_roll)) begin
      count_low_byte <= reload_low_byte; // RULE_02 RULE_05
    end else if (low_en) begin
      count_low_byte <= count_low_byte + dmrt_pkg::BYTE_ONE;
    end
  end

  // High count byte; software write wins, then reload on a high roll
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count_high_byte <= dmrt_pkg::RESET_BYTE;
    end else if (wr_hit(wr, dmrt_pkg::ADDR_COUNT_HIGH)) begin
      count_high_byte <= wr.wdata; // RULE_15 RULE_17
    end else if (high_roll) begin
      count_high_byte <= reload_high_byte; // RULE_02 RULE_05
    end else if (high_en) begin
      count_high_byte <= count_high_byte + dmrt_pkg::BYTE_ONE;
    end
  end

  // Reload bytes, also the capture target
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reload_low_byte <= dmrt_pkg::RESET_BYTE;
      reload_high_byte <= dmrt_pkg::RESET_BYTE;
    end else begin
      if (wr_hit(wr, dmrt_pkg::ADDR_RELOAD_LOW)) begin
        reload_low_byte <= wr.wdata; // RULE_17
      end else if (capture) begin
        reload_low_byte <= count_low_byte; // RULE_12
      end
      if (wr_hit(wr, dmrt_pkg::ADDR_RELOAD_HIGH)) begin
        reload_high_byte <= wr.wdata; // RULE_17
      end else if (capture) begin
        reload_high_byte <= count_high_byte; // RULE_12
      end
    end
  end

  // Control; hardware set beats a same-cycle software clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timer_control <= dmrt_pkg::CONTROL_RESET; // RULE_13
    end else begin
      if (wr_hit(wr, dmrt_pkg::ADDR_CONTROL)) begin
        timer_control <= dmrt_pkg::dmrt_control_s'(wr.wdata);
        timer_control.unused_bit <= 1'b0; // RULE_14
      end
      if (high_roll) begin
        timer_control.high_overflow_flag <= 1'b1; // RULE_02 RULE_09 RULE_11
      end
      if (low_roll) begin
        timer_control.low_overflow_flag <= 1'b1; // RULE_09 RULE_11
      end
    end
  end

  // Capture holds no flag of its own, so it pulses the request for one cycle
  always_comb begin
    next_irq = timer_irq_en && (timer_control.high_overflow_flag
      || (timer_control.low_overflow_flag && timer_control.low_irq_en) || capture); // RULE_03 RULE_04 RULE_10 RULE_16
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= next_irq; // RULE_16
    end
  end

  // Registered read port, unmapped reads zero
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sfr_rdata <= dmrt_pkg::RESET_BYTE;
    end else begin
      unique case (sfr_addr)
        dmrt_pkg::ADDR_CONTROL: sfr_rdata <= timer_control;
        dmrt_pkg::ADDR_RELOAD_LOW: sfr_rdata <= reload_low_byte;
        dmrt_pkg::ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_byte;
        dmrt_pkg::ADDR_COUNT_LOW: sfr_rdata <= count_low_byte; // RULE_15
        dmrt_pkg::ADDR_COUNT_HIGH: sfr_rdata <= count_high_byte; // RULE_15
        default: sfr_rdata <= dmrt_pkg::RESET_BYTE;
      endcase
    end
  end

  sequence s_high_wrap;
    high_roll && !wr_hit(wr, dmrt_pkg::ADDR_COUNT_HIGH);
  endsequence

  sequence s_joined_wrap;
    !timer_control.split_mode_sel && high_roll && !wr.wr_en;
  endsequence

  AST_JOINED_RELOAD: assert property (@(posedge clock) disable iff (!rst_b) // RULE_02
    s_joined_wrap |=> count_low_byte == $past(reload_low_byte) && count_high_byte == $past(reload_high_byte))
    else $error("joined wrap did not reload");
  AST_HIGH_FLAG: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
    s_high_wrap |=> timer_control.high_overflow_flag) else $error("high flag not set");
  AST_LOW_FLAG: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
    low_roll |=> timer_control.low_overflow_flag) else $error("low flag not set");
  AST_NO_HW_CLEAR: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
    timer_control.high_overflow_flag && !wr_hit(wr, dmrt_pkg::ADDR_CONTROL) |=> timer_control.high_overflow_flag)
    else $error("flag cleared by hardware");
  AST_SPLIT_LOW_RUNS: assert property (@(posedge clock) disable iff (!rst_b) // RULE_06
    timer_control.split_mode_sel && low_byte_clk_sel && !low_roll && !wr.wr_en
    |=> count_low_byte == $past(count_low_byte) + dmrt_pkg::BYTE_ONE) else $error("split low counter stalled");
  AST_STOPPED_HIGH: assert property (@(posedge clock) disable iff (!rst_b) // RULE_06
    !timer_control.run_ctrl && !wr.wr_en |=> $stable(count_high_byte)) else $error("high ran while stopped");
  AST_BIT1_ZERO: assert property (@(posedge clock) disable iff (!rst_b) // RULE_14
    sfr_addr == dmrt_pkg::ADDR_CONTROL |=> !sfr_rdata[1]) else $error("unused bit read one");
  AST_WRITE_WINS: assert property (@(posedge clock) disable iff (!rst_b) // RULE_17
    wr_hit(wr, dmrt_pkg::ADDR_COUNT_LOW) |=> count_low_byte == $past(sfr_wdata)) else $error("write lost");
  AST_IRQ_GATE: assert property (@(posedge clock) disable iff (!rst_b) // RULE_16
    timer_irq_en && timer_control.high_overflow_flag |=> irq_req) else $error("irq missing");
  AST_IRQ_OFF: assert property (@(posedge clock) disable iff (!rst_b) // RULE_03
    !timer_irq_en |=> !irq_req) else $error("irq without enable");
  AST_CAPTURE: assert property (@(posedge clock) disable iff (!rst_b) // RULE_12
    capture && !wr.wr_en |=> reload_low_byte == $past(count_low_byte) && irq_req) else $error("capture failed");

  // Reset state, checked without the disable so it is really seen
  AST_RESET_CLEAR: assert property (@(posedge clock) // RULE_13
    !rst_b |=> timer_control == dmrt_pkg::CONTROL_RESET && !irq_req && sfr_rdata == dmrt_pkg::RESET_BYTE)
    else $error("reset state wrong");

  sequence s_split_low_wrap;
    timer_control.split_mode_sel && low_roll && !wr_hit(wr, dmrt_pkg::ADDR_COUNT_LOW);
  endsequence

  sequence s_split_high_wrap;
    timer_control.split_mode_sel && high_roll && !wr_hit(wr, dmrt_pkg::ADDR_COUNT_HIGH);
  endsequence

  AST_SPLIT_LOW_RELOAD: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
    s_split_low_wrap |=> count_low_byte == $past(reload_low_byte)) else $error("split low did not reload");
  AST_SPLIT_HIGH_RELOAD: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
    s_split_high_wrap |=> count_high_byte == $past(reload_high_byte)) else $error("split high did not reload");
  AST_SPLIT_HIGH_STEP: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
    timer_control.split_mode_sel && high_en && count_high_byte != dmrt_pkg::BYTE_MAX
    && !wr_hit(wr, dmrt_pkg::ADDR_COUNT_HIGH)
    |=> count_high_byte == $past(count_high_byte) + dmrt_pkg::BYTE_ONE) else $error("split high did not step");

  // Low byte wrap without a full wrap carries into the high byte
  sequence s_joined_carry;
    !timer_control.split_mode_sel && low_en && count_low_byte == dmrt_pkg::BYTE_MAX
    && count_high_byte != dmrt_pkg::BYTE_MAX && !wr.wr_en;
  endsequence

  AST_JOINED_CARRY: assert property (@(posedge clock) disable iff (!rst_b) // RULE_01
    s_joined_carry |=> count_high_byte == $past(count_high_byte) + dmrt_pkg::BYTE_ONE
    && count_low_byte == dmrt_pkg::RESET_BYTE) else $error("joined carry wrong");
  AST_STOPPED_LOW: assert property (@(posedge clock) disable iff (!rst_b) // RULE_06
    !timer_control.split_mode_sel && !timer_control.run_ctrl && !wr.wr_en |=> $stable(count_low_byte))
    else $error("joined low ran while stopped");
  AST_SYS_SEL_STEP: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
    !timer_control.split_mode_sel && timer_control.run_ctrl && low_byte_clk_sel
    && count_low_byte != dmrt_pkg::BYTE_MAX && !wr_hit(wr, dmrt_pkg::ADDR_COUNT_LOW)
    |=> count_low_byte == $past(count_low_byte) + dmrt_pkg::BYTE_ONE) else $error("system clock step missed");

  // Divider pulse is one cycle wide and repeats every twelfth cycle
  sequence s_sys_gap;
    !sys_tick [*8];
  endsequence

  AST_SYS_GAP: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
    sys_tick |=> s_sys_gap) else $error("divider tick too close");
  AST_SYS_PERIOD: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
    sys_tick |-> ##12 sys_tick) else $error("divider period wrong");
  AST_EXT_PULSE: assert property (@(posedge clock) disable iff (!rst_b) // RULE_08
    ext_tick |=> !ext_tick) else $error("external tick too long");

  AST_LOW_NO_HW_CLEAR: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
    timer_control.low_overflow_flag && !wr_hit(wr, dmrt_pkg::ADDR_CONTROL) |=> timer_control.low_overflow_flag)
    else $error("low flag cleared by hardware");
  AST_LOW_IRQ: assert property (@(posedge clock) disable iff (!rst_b) // RULE_10
    timer_irq_en && timer_control.low_overflow_flag && timer_control.low_irq_en |=> irq_req)
    else $error("low irq missing");
  AST_IRQ_QUIET: assert property (@(posedge clock) disable iff (!rst_b) // RULE_16
    !timer_control.high_overflow_flag && !(timer_control.low_overflow_flag && timer_control.low_irq_en)
    && !capture |=> !irq_req) else $error("irq without cause");

  AST_CAPTURE_HIGH: assert property (@(posedge clock) disable iff (!rst_b) // RULE_12
    capture && !wr.wr_en |=> reload_high_byte == $past(count_high_byte)) else $error("capture high failed");
  AST_NO_CAPTURE_OFF: assert property (@(posedge clock) disable iff (!rst_b) // RULE_12
    !timer_irq_en && !wr.wr_en |=> $stable(reload_low_byte) && $stable(reload_high_byte))
    else $error("reload moved without enable");

  AST_RELOAD_WRITE: assert property (@(posedge clock) disable iff (!rst_b) // RULE_17
    wr_hit(wr, dmrt_pkg::ADDR_RELOAD_LOW) |=> reload_low_byte == $past(sfr_wdata)) else $error("reload write lost");
  AST_HIGH_WRITE_WINS: assert property (@(posedge clock) disable iff (!rst_b) // RULE_17
    wr_hit(wr, dmrt_pkg::ADDR_COUNT_HIGH) |=> count_high_byte == $past(sfr_wdata)) else $error("high write lost");
  AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (!rst_b) // RULE_14
    wr_hit(wr, dmrt_pkg::ADDR_CONTROL) && !high_roll && !low_roll
    |=> timer_control == {$past(sfr_wdata[7:2]), 1'b0, $past(sfr_wdata[0])}) else $error("control write wrong");

  // Reads reflect the register as it stood at the address edge
  AST_READ_COUNT: assert property (@(posedge clock) disable iff (!rst_b) // RULE_15
    sfr_addr == dmrt_pkg::ADDR_COUNT_LOW |=> sfr_rdata == $past(count_low_byte)) else $error("count read wrong");
  AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (!rst_b) // RULE_15
    !(sfr_addr inside {[dmrt_pkg::ADDR_CONTROL:dmrt_pkg::ADDR_COUNT_HIGH]}) |=> sfr_rdata == dmrt_pkg::RESET_BYTE)
    else $error("unmapped read not zero");

endmodule // dmrt_timer

// ---- sim/tb_dual_mode_reload_timer.sv ----
`timescale 1ns/1ps
module tb_dual_mode_reload_timer;
  localparam logic [7:0] CTL = dmrt_pkg::ADDR_CONTROL;
  localparam logic [7:0] RLL = dmrt_pkg::ADDR_RELOAD_LOW;
  localparam logic [7:0] RLH = dmrt_pkg::ADDR_RELOAD_HIGH;
  localparam logic [7:0] CNL = dmrt_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] CNH = dmrt_pkg::ADDR_COUNT_HIGH;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic high_byte_clk_sel = 1'b1;
  logic low_byte_clk_sel = 1'b1;
  logic timer_irq_en = 1'b0;
  logic ext_osc_clk = 1'b0;
  logic lfo_out = 1'b0;
  logic irq_req;
  logic [1:0] ext_phase = 2'h0;
  logic [7:0] got;
  int hi_cnt;
  int mismatches = 0;
  int checks = 0;

  dmrt_timer dmrt_timer_inst (.clock(clock), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .high_byte_clk_sel(high_byte_clk_sel),
    .low_byte_clk_sel(low_byte_clk_sel), .timer_irq_en(timer_irq_en), .ext_osc_clk(ext_osc_clk),
    .lfo_out(lfo_out), .irq_req(irq_req));

  always #20 clock = ~clock;

  // Pin toggles every third cycle, so one divided tick per 48 cycles
  always @(negedge clock) begin
    ext_phase <= (ext_phase == 2'h2) ? 2'h0 : ext_phase + 2'h1;
    if (ext_phase == 2'h2) ext_osc_clk <= ~ext_osc_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask

  // Low byte first, high byte at the next address
  task automatic wr2(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(8'(a + 8'h01), v[15:8]);
  endtask

  // Read data is registered; taken at the falling edge after the address edge
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    sfr_addr = a;
    @(posedge clock);
    @(negedge clock);
    got = sfr_rdata;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    rd(a);
    chk($sformatf("reg_%h", a), exp, got & m);
  endtask

  // Free-running counts drift a little with access latency
  task automatic rrng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    rd(a);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH reg_%h expected %h to %h seen %h", a, lo, hi, got);
    end
  endtask

  task automatic ichk(input logic exp);
    chk("irq_req", {7'h00, exp}, {7'h00, irq_req});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    cyc(8);
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) rchk(8'(CTL + i), 8'hFF, 8'h00);
    wr(CTL, 8'h2B);
    rchk(CTL, 8'hFF, 8'h29);
    wr(8'h96, 8'h5A);
    wr(CTL, 8'h00);
    for (int i = 1; i < 5; i++) wr(8'(CTL + i), 8'(8'hA0 + i));
    for (int i = 1; i < 6; i++) rchk(8'(CTL + i), 8'hFF, (i == 5) ? 8'h00 : 8'(8'hA0 + i));
    timer_irq_en = 1'b1;
    wr2(RLL, 16'h1234);
    wr2(CNL, 16'hFFFE);
    wr(CTL, 8'h04);
    cyc(4);
    rchk(CTL, 8'h84, 8'h84);
    rchk(CNH, 8'hFF, 8'h12);
    ichk(1'b1);
    cyc(20);
    rchk(CTL, 8'h80, 8'h80);
    wr(CTL, 8'h00);
    cyc(2);
    ichk(1'b0);
    wr2(CNL, 16'h00FE);
    wr(CTL, 8'h24);
    cyc(4);
    rchk(CTL, 8'hC0, 8'h40);
    rchk(CNH, 8'hFF, 8'h01);
    ichk(1'b1);
    wr(CTL, 8'h40);
    cyc(2);
    ichk(1'b0);
    wr(CTL, 8'h60);
    cyc(2);
    ichk(1'b1);
    timer_irq_en = 1'b0;
    cyc(2);
    ichk(1'b0);
    timer_irq_en = 1'b1;
    wr(CTL, 8'h00);
    wr2(RLL, 16'h5580);
    wr2(CNL, 16'hFEFE);
    wr(CTL, 8'h08);
    cyc(6);
    rchk(CNH, 8'hFF, 8'hFE);
    rchk(CTL, 8'hC0, 8'h40);
    rrng(CNL, 8'h80, 8'h95);
    ichk(1'b0);
    wr(CTL, 8'h0C);
    cyc(6);
    rrng(CNH, 8'h55, 8'h60);
    rchk(CTL, 8'h80, 8'h80);
    ichk(1'b1);
    wr(CTL, 8'h00);
    low_byte_clk_sel = 1'b0;
    high_byte_clk_sel = 1'b0;
    wr2(CNL, 16'h0000);
    wr(CTL, 8'h04);
    cyc(120);
    wr(CTL, 8'h00);
    rrng(CNL, 8'h09, 8'h0B);
    wr2(CNL, 16'h0000);
    wr(CTL, 8'h05);
    cyc(240);
    wr(CTL, 8'h01);
    rrng(CNL, 8'h04, 8'h06);
    high_byte_clk_sel = 1'b1;
    wr2(CNL, 16'h0000);
    wr(CTL, 8'h0D);
    cyc(40);
    wr(CTL, 8'h09);
    rrng(CNH, 8'h28, 8'h2C);
    low_byte_clk_sel = 1'b1;
    timer_irq_en = 1'b0;
    wr(CTL, 8'h00);
    wr2(CNL, 16'h1111);
    wr(CTL, 8'h10);
    lfo_out = 1'b1;
    cyc(8);
    rchk(RLL, 8'hFF, 8'h80);
    lfo_out = 1'b0;
    timer_irq_en = 1'b1;
    wr2(CNL, 16'hABCD);
    cyc(4);
    lfo_out = 1'b1;
    hi_cnt = 0;
    repeat (12) begin
      cyc(1);
      if (irq_req === 1'b1) hi_cnt++;
    end
    chk("capture_irq", 8'h01, 8'(hi_cnt));
    if (hi_cnt != 0) begin
      rchk(RLL, 8'hFF, 8'hCD);
      rchk(RLH, 8'hFF, 8'hAB);
    end
    complete_run();
  end
endmodule // tb_dual_mode_reload_timer
